// ### core_reset_checker.sv
// Port assertions for the core reset sequencer.
// Bound into each sequencer; SLOW_DIV follows it.
`timescale 1ns/1ps
`default_nettype none
module core_reset_checker #(
	parameter int unsigned SLOW_DIV = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic backupResetInN,
	input wire logic coreSupplyGood,
	input wire logic shutdownReq,
	input wire logic supplyMonitorDetect,
	input wire logic supplyMonitorResetEn,
	input wire logic brownoutOk,
	input wire logic brownoutResetEn,
	input wire logic coreResetN,
	input wire logic regulatorStandby,
	input wire logic regulatorShutdownOut,
	input wire logic supplyMonitorEvent,
	input wire logic brownoutEvent
);
	int lowCnt;
	int bodCnt;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn || !backupResetInN);
	//////////////////////////////
	// Run lengths; loose, as the divider phase is free
	always_ff @(posedge clk) begin
		lowCnt <= (coreResetN || !resetn) ? 0 : lowCnt + 1;
		bodCnt <= (brownoutOk || !resetn) ? 0 : bodCnt + 1;
	end
	// Outputs tied to their causes
	a_backup_clear: assert property (disable iff (!resetn)
		!backupResetInN |=> !coreResetN && !regulatorStandby)
		else $error("backup reset ignored");
	a_regulator_shutdown_out_mirror: assert property (
		regulatorShutdownOut == regulatorStandby) else $error("regulator_shutdown_out");
	a_event_follow: assert property (
		supplyMonitorDetect |=> supplyMonitorEvent) else $error("event");
	a_sm_reset: assert property (coreResetN && supplyMonitorDetect
		&& supplyMonitorResetEn |=> !coreResetN) else $error("sm");
	a_hold_min: assert property (
		$rose(coreResetN) |-> lowCnt >= SLOW_DIV) else $error("hold");
	a_supply_ok: assert property (
		$rose(coreResetN) |-> $past(coreSupplyGood)) else $error("supply");
	a_reset_first: assert property (
		regulatorStandby |-> !coreResetN) else $error("standby");
	a_bod_qualify: assert property (
		$rose(brownoutEvent) |-> bodCnt >= SLOW_DIV) else $error("bod");
	a_bod_reset: assert property (
		brownoutEvent && $past(brownoutResetEn) |-> !coreResetN)
		else $error("bodrst");
	a_no_spurious: assert property (coreResetN && !shutdownReq
		&& !(supplyMonitorDetect && supplyMonitorResetEn)
		&& ((brownoutOk && $past(brownoutOk)) || !brownoutResetEn)
		|=> coreResetN)
		else $error("spurious");
	c_fault: cover property ($fell(coreResetN));
	c_bod: cover property ($rose(brownoutEvent));
	c_standby: cover property ($rose(regulatorStandby));
endmodule
bind supply_core_reset_control core_reset_checker #(
	.SLOW_DIV (SLOW_DIV)
) u_chk (
	.clk                  (clk),
	.resetn               (resetn),
	.backupResetInN       (backupResetInN),
	.coreSupplyGood       (coreSupplyGood),
	.shutdownReq          (shutdownReq),
	.supplyMonitorDetect  (supplyMonitorDetect),
	.supplyMonitorResetEn (supplyMonitorResetEn),
	.brownoutOk           (brownoutOk),
	.brownoutResetEn      (brownoutResetEn),
	.coreResetN           (coreResetN),
	.regulatorStandby     (regulatorStandby),
	.regulatorShutdownOut (regulatorShutdownOut),
	.supplyMonitorEvent   (supplyMonitorEvent),
	.brownoutEvent        (brownoutEvent)
);
`default_nettype wire

// ### far_side_model.sv
// Regulator and reset controller beyond the sequencer.
// Assumes the sequencer clock; supply ramps after wake.
`timescale 1ns/1ps
`default_nettype none
module far_side_model #(
	parameter int RAMP = 5
) (
	input  wire logic clk,
	input  wire logic coreResetN,
	input  wire logic regulatorShutdownOut,
	output var  logic coreSupplyGood,
	output var  logic downstreamResetN
);
	int ramp = 0;
	//////////////////////////////
	// Supply is lost at once on shutdown, good only after a ramp
	always @(posedge clk)
		ramp <= regulatorShutdownOut ? 0 : (ramp < RAMP ? ramp + 1 : ramp);
	assign coreSupplyGood = (ramp == RAMP);
	// Peripheral, processor and debug resets follow core reset
	assign downstreamResetN = coreResetN;
endmodule
`default_nettype wire

// ### slow_tick_gen.sv
// Slow clock enable generator.
// Assumes a single free-running system clock and synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module slow_tick_gen #(
	parameter int unsigned DIV = 7630
) (
	input  wire logic clk,
	input  wire logic resetn,
	output var  logic tick
);

	localparam int unsigned CW = $clog2(DIV + 1);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;
	logic          tick_q;
	logic          tick_d;

	// Wrap counter, one pulse per slow period
	always_comb begin
		tick_d  = 1'b0;
		count_d = count_q + 1'b1;
		if (count_q == LAST) begin
			count_d = '0;
			tick_d  = 1'b1;
		end
	end

	// Registers only
	always_ff @(posedge clk) begin
		if (!resetn) begin
			count_q <= '0;
			tick_q  <= 1'b0;
		end else begin
			count_q <= count_d;
			tick_q  <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule
`default_nettype wire

// ### supply_core_reset_control.sv
// Core-domain reset sequencer of the supply controller.
// Assumes inputs synchronous to clk; resetn stands for the power-on cell.
`timescale 1ns/1ps
`default_nettype none
module supply_core_reset_control #(
	parameter int unsigned SLOW_DIV =
		supply_core_reset_pkg::SLOW_DIV_CYCLES
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic backupResetInN,
	input  wire logic coreSupplyGood,
	input  wire logic shutdownReq,
	input  wire logic supplyMonitorDetect,
	input  wire logic supplyMonitorResetEn,
	input  wire logic brownoutOk,
	input  wire logic brownoutResetEn,
	output var  logic coreResetN,
	output var  logic regulatorStandby,
	output var  logic regulatorShutdownOut,
	output var  logic supplyMonitorEvent,
	output var  logic brownoutEvent
);
	import supply_core_reset_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Slow clock enable

	logic slowTick;

	slow_tick_gen #(
		.DIV (SLOW_DIV)
	) uSlowTick (
		.clk    (clk),
		.resetn (resetn),
		.tick   (slowTick)
	);

	////////////////////////////////////////////////////////////////////////
	// Detection qualification

	logic                  sysResetN;
	logic                  smFault;
	logic                  bodFault;
	logic                  bodLost;
	logic [TICK_CNT_W-1:0] lossTicks_q;
	logic [TICK_CNT_W-1:0] lossTicks_d;

	// Power-on cell and backup pin reset the sequencer alike; the slow tick generator is reset by resetn only
	assign sysResetN = resetn && backupResetInN;

	// Brownout only counts while the regulator is running
	assign bodLost = !brownoutOk && !regulatorStandby;

	// Loss must outlast one slow period; short dips never reach the count
	always_comb begin
		lossTicks_d = lossTicks_q;
		if (!bodLost) begin
			lossTicks_d = '0;
		end else if (slowTick && lossTicks_q != LOSS_TICKS) begin
			lossTicks_d = lossTicks_q + 1'b1;
		end
	end

	// Enables gate the reset path only
	assign smFault  = supplyMonitorDetect && supplyMonitorResetEn;
	assign bodFault = (lossTicks_q == LOSS_TICKS)
		&& brownoutResetEn;

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	seq_state_t            state_q;
	seq_state_t            state_d;
	logic [TICK_CNT_W-1:0] holdTicks_q;
	logic [TICK_CNT_W-1:0] holdTicks_d;
	logic                  coreResetN_q;
	logic                  coreResetN_d;
	logic                  standby_q;
	logic                  standby_d;
	logic                  smEvent_q;
	logic                  smEvent_d;
	logic                  bodEvent_q;
	logic                  bodEvent_d;
	logic                  holdDone;

	assign holdDone = (holdTicks_q == HOLD_TICKS);

	// Next state, reset level and standby level
	always_comb begin
		state_d      = state_q;
		holdTicks_d  = holdTicks_q;
		coreResetN_d = coreResetN_q;
		standby_d    = standby_q;
		// Detections are reported whatever the enables say
		smEvent_d    = supplyMonitorDetect;
		bodEvent_d   = (lossTicks_q == LOSS_TICKS);
		if (slowTick && !holdDone) begin
			holdTicks_d = holdTicks_q + 1'b1;
		end
		case (state_q)
			ST_POR: begin
				// Same start-up as raising the backup supply
				coreResetN_d = 1'b0;
				standby_d    = 1'b0;
				holdTicks_d  = '0;
				state_d      = ST_WAIT_SUP;
			end
			ST_WAIT_SUP: begin
				coreResetN_d = 1'b0;
				// Release only with a regulated core supply
				// A live enabled fault keeps reset low here too
				if (coreSupplyGood && holdDone && !smFault && !bodFault) begin
					coreResetN_d = 1'b1;
					state_d      = ST_RUN;
				end
			end
			ST_RUN: begin
				if (smFault || bodFault) begin
					// Immediate assertion on the next edge
					coreResetN_d = 1'b0;
					holdTicks_d  = '0;
					state_d      = ST_HOLD;
				end else if (shutdownReq) begin
					// Reset first, supply off a cycle later
					coreResetN_d = 1'b0;
					state_d      = ST_STANDBY;
				end
			end
			ST_HOLD: begin
				// At least one full slow cycle of reset
				coreResetN_d = 1'b0;
				if (holdDone && !smFault && !bodFault) begin
					state_d = ST_WAIT_SUP;
				end
			end
			ST_STANDBY: begin
				coreResetN_d = 1'b0;
				standby_d    = shutdownReq;
				if (!shutdownReq) begin
					holdTicks_d = '0;
					state_d     = ST_WAIT_SUP;
				end
			end
			default: begin
				coreResetN_d = 1'b0;
				standby_d    = 1'b0;
				state_d      = ST_POR;
			end
		endcase
	end

	// Registers only; backup pin acts as a full reset
	always_ff @(posedge clk) begin
		if (!sysResetN) begin
			state_q      <= ST_POR;
			holdTicks_q  <= '0;
			lossTicks_q  <= '0;
			coreResetN_q <= 1'b0;
			standby_q    <= 1'b0;
			smEvent_q    <= 1'b0;
			bodEvent_q   <= 1'b0;
		end else begin
			state_q      <= state_d;
			holdTicks_q  <= holdTicks_d;
			lossTicks_q  <= lossTicks_d;
			coreResetN_q <= coreResetN_d;
			standby_q    <= standby_d;
			smEvent_q    <= smEvent_d;
			bodEvent_q   <= bodEvent_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Reset controller fans this out to all downstream resets
	assign coreResetN           = coreResetN_q;
	assign regulatorStandby     = standby_q;
	assign regulatorShutdownOut = standby_q;  // Same flop as standby
	assign supplyMonitorEvent   = smEvent_q;
	assign brownoutEvent        = bodEvent_q;

endmodule
`default_nettype wire

// ### supply_core_reset_pkg.sv
// Constants shared by the supply controller core reset logic.
// Assumes a single 250 MHz system clock and a slow clock built as an enable.
package supply_core_reset_pkg;

	// System clock rate
	localparam int unsigned CLK_HZ = 250_000_000;
	// Slow clock rate
	localparam int unsigned SLOW_CLK_HZ = 32_768;
	// System cycles per slow cycle, rounded up so a slow period is never short
	localparam int unsigned SLOW_DIV_CYCLES =
		(CLK_HZ + SLOW_CLK_HZ - 1) / SLOW_CLK_HZ;

	// Width of the slow-tick counters
	localparam int unsigned TICK_CNT_W = 2;
	// Slow ticks seen to guarantee at least one whole slow period has passed
	localparam logic [1:0] HOLD_TICKS = 2'h2;
	// Slow ticks of lost brownout-ok that prove more than one slow period
	localparam logic [1:0] LOSS_TICKS = 2'h2;

	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_POR      = 5'h01,
		ST_WAIT_SUP = 5'h02,
		ST_RUN      = 5'h04,
		ST_HOLD     = 5'h08,
		ST_STANDBY  = 5'h10
	} seq_state_t;

endpackage

// ### testbench.sv
// Self-checking bench for the core reset sequencer.
// Assumes the checker is bound and the far side modelled.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int unsigned DIV = 8;
	logic clk = 0, resetn = 0, bkN = 1, shut = 0, det = 0, smEn = 0;
	logic bodOk = 1, bodEn = 0, good, rstN, stby, regulator_shutdown_out, smEv, bodEv;
	int   n_errors = 0;
	int   checked = 0;
	int   seed = 19;
	int   i;
	bit   detQ[$];
	supply_core_reset_control #(.SLOW_DIV(DIV)) u_dut (.clk(clk),
		.resetn(resetn), .backupResetInN(bkN), .coreSupplyGood(good),
		.shutdownReq(shut), .supplyMonitorDetect(det),
		.supplyMonitorResetEn(smEn), .brownoutOk(bodOk),
		.brownoutResetEn(bodEn), .coreResetN(rstN), .regulatorStandby(stby),
		.regulatorShutdownOut(regulator_shutdown_out), .supplyMonitorEvent(smEv),
		.brownoutEvent(bodEv));
	far_side_model u_far (.clk(clk), .coreResetN(rstN),
		.regulatorShutdownOut(regulator_shutdown_out), .coreSupplyGood(good),
		.downstreamResetN());
	//////////////////////////////
	task check(input logic seen, input logic exp, input string nm);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s exp %b seen %b", nm, exp, seen);
		end
	endtask
	// One cycle; the event flag mirrors the detect just sampled
	task tick;
		detQ.push_back(det);
		@(posedge clk);
		#1;
		if (resetn && bkN) check(smEv, detQ[0], "event");
		detQ.delete(0);
		check(regulator_shutdown_out, stby, "shutdown");
		@(negedge clk);
	endtask
	task run(input int n);
		repeat (n) tick;
	endtask
	// Bounded wait for the core reset level
	task waitFor(input logic v);
		for (i = 0; i < 300 && rstN !== v; i++) tick;
		check(rstN, v, "coreReset");
	endtask
	task final_report;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial forever #2 clk = ~clk;
	// Watchdog well beyond the expected run
	initial begin
		#20000;
		n_errors++;
		final_report;
	end
	// Stimulus, driven on falling edges
	initial begin
		repeat (16) @(negedge clk);
		resetn = 1;
		waitFor(1);
		repeat (40) begin
			det = $random(seed) % 2 != 0;
			tick;
		end
		check(rstN, 1, "coreReset");
		det = 1;
		smEn = 1;
		run(1);
		check(rstN, 0, "coreReset");
		det = 0;
		waitFor(1);
		bodEn = 1;
		bodOk = 0;
		run(3);
		bodOk = 1;
		run(3 * DIV);
		check(rstN, 1, "coreReset");
		bodOk = 0;
		run(3 * DIV);
		check(bodEv, 1, "brownout");
		check(rstN, 0, "coreReset");
		bodOk = 1;
		bodEn = 0;
		waitFor(1);
		bodOk = 0;
		run(3 * DIV);
		check(bodEv, 1, "brownout");
		check(rstN, 1, "coreReset");
		bodOk = 1;
		shut = 1;
		run(3);
		check(stby, 1, "standby");
		check(bodEv, 0, "brownout");
		shut = 0;
		waitFor(1);
		bkN = 0;
		run(2);
		check(rstN, 0, "coreReset");
		bkN = 1;
		waitFor(1);
		final_report;
	end
endmodule
`default_nettype wire
